//--- design/lin_ctrl_pkg.sv
package lin_ctrl_pkg;

   // register byte addresses
   localparam logic [31:0] ADDR_CONFIG = 32'h4000_1800;
   localparam logic [31:0] ADDR_STATUS = 32'h4000_1804;
   localparam logic [31:0] ADDR_DATA = 32'h4000_1808;
   localparam logic [31:0] ADDR_IRQ_EN = 32'h4000_180c;
   localparam logic [31:0] ADDR_DIV_LOW = 32'h4000_1810;
   localparam logic [31:0] ADDR_DIV_HIGH = 32'h4000_1814;

   localparam int CFG_TIMER_EN_BIT = 3;

   localparam int DIV_W = 15;
   localparam int DIV_LOW_W = 8;
   localparam int DIV_HIGH_W = 7;
   localparam logic [7:0] DIV_LOW_RESET = 8'he7;
   localparam logic [6:0] DIV_HIGH_RESET = 7'h03;

   localparam logic [7:0] STATUS_RESET = 8'h04;
   // flags that a status read clears
   localparam logic [7:0] STATUS_RC_MASK = 8'hf9;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;

   // break is a dominant run longer than this many bit times
   localparam int BREAK_BITS = 11;
   // sync field 0x55: falling edges 1..5 span eight bit times
   localparam int SYNC_FALL_EDGES = 5;
   localparam int SYNC_SPAN_SHIFT = 3;
   localparam int SD_CNT_W = 20;

   localparam int FRAME_LAST_BIT = 9;

   localparam int CLK_FREQ_KHZ = 125000;
   localparam int INACTIVE_TIME_MS = 4000;
   localparam int INACTIVE_CYCLES = INACTIVE_TIME_MS * CLK_FREQ_KHZ;

   typedef struct packed {
      logic bus_inactive;
      logic transmitter_forced_off;
      logic write_collision;
      logic receive_overrun;
      logic conflict;
      logic transmit_buffer_empty;
      logic receive_buffer_full;
      logic break_field_seen;
   } status_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } reg_req_type;

endpackage

//--- design/lin_controller.sv
`timescale 1ns/100ps
module lin_controller #(
   parameter int unsigned INACTIVE_CYCLES = lin_ctrl_pkg::INACTIVE_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire lin_ctrl_pkg::reg_req_type reg_req_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o,
   input wire logic lin_rx_i,
   output logic lin_tx_o
);

   typedef enum logic [1:0] {
      SD_IDLE,
      SD_LOW,
      SD_WAIT_START,
      SD_MEASURE
   } sd_state_type;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } rx_state_type;

   typedef enum logic {
      TX_IDLE,
      TX_BIT
   } tx_state_type;

   lin_ctrl_pkg::status_type status_ff;
   lin_ctrl_pkg::status_type nxt_status;
   logic [7:0] irq_en_ff;
   logic irq_ff;
   logic [31:0] rdata_ff;
   logic timer_en_ff;
   logic [lin_ctrl_pkg::DIV_LOW_W-1:0] div_low_ff;
   logic [lin_ctrl_pkg::DIV_HIGH_W-1:0] div_high_ff;
   logic [lin_ctrl_pkg::DIV_W-1:0] divisor;
   logic [15:0] bit_len;
   logic [15:0] half_bit;

   logic rx_meta_ff;
   logic rx_sync_ff;
   logic rx_prev_ff;
   logic bus_fall;
   logic bus_rise;

   logic wr_config;
   logic wr_data;
   logic wr_irq_en;
   logic wr_div_low;
   logic wr_div_high;
   logic rd_status;
   logic rd_data;

   sd_state_type sd_state_ff;
   logic [lin_ctrl_pkg::SD_CNT_W-1:0] sd_cnt_ff;
   logic [2:0] sd_edges_ff;
   logic [lin_ctrl_pkg::SD_CNT_W-1:0] break_thr;
   logic [lin_ctrl_pkg::SD_CNT_W-1:0] sync_span;
   logic sync_done;

   rx_state_type rx_state_ff;
   logic rx_en_ff;
   logic [15:0] rx_cnt_ff;
   logic [2:0] rx_bits_ff;
   logic [7:0] rx_shift_ff;
   logic [7:0] rx_buf_ff;
   logic rx_store;

   tx_state_type tx_state_ff;
   logic [7:0] tx_buf_ff;
   logic [8:0] tx_shift_ff;
   logic [15:0] tx_cnt_ff;
   logic [3:0] tx_bits_ff;
   logic lin_tx_ff;
   logic tx_load;
   logic tx_conflict;
   logic tx_forced_off;
   logic tx_active;

   logic [31:0] idle_cnt_ff;
   logic idle_fired_ff;
   logic idle_expire;

   assign divisor = {div_high_ff, div_low_ff};
   assign bit_len = 16'({1'b0, divisor}) + 16'h0001;
   assign half_bit = {1'b0, bit_len[15:1]};
   assign tx_active = (tx_state_ff == TX_BIT);

   // bus pin synchroniser; only the second and third stages feed logic
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_meta_ff <= 1'b1;
         rx_sync_ff <= 1'b1;
         rx_prev_ff <= 1'b1;
      end else begin
         rx_meta_ff <= lin_rx_i;
         rx_sync_ff <= rx_meta_ff;
         rx_prev_ff <= rx_sync_ff;
      end
   end

   assign bus_fall = rx_prev_ff & ~rx_sync_ff;
   assign bus_rise = ~rx_prev_ff & rx_sync_ff;

   // register decode
   assign wr_config = reg_req_i.wr &&
                      (reg_req_i.addr == lin_ctrl_pkg::ADDR_CONFIG);
   assign wr_data = reg_req_i.wr &&
                    (reg_req_i.addr == lin_ctrl_pkg::ADDR_DATA);
   assign wr_irq_en = reg_req_i.wr &&
                      (reg_req_i.addr == lin_ctrl_pkg::ADDR_IRQ_EN);
   assign wr_div_low = reg_req_i.wr &&
                       (reg_req_i.addr == lin_ctrl_pkg::ADDR_DIV_LOW);
   assign wr_div_high = reg_req_i.wr &&
                        (reg_req_i.addr == lin_ctrl_pkg::ADDR_DIV_HIGH);
   assign rd_status = reg_req_i.rd &&
                      (reg_req_i.addr == lin_ctrl_pkg::ADDR_STATUS);
   assign rd_data = reg_req_i.rd &&
                    (reg_req_i.addr == lin_ctrl_pkg::ADDR_DATA);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         timer_en_ff <= 1'b0;
      end else if (wr_config) begin
         timer_en_ff <= reg_req_i.wdata[lin_ctrl_pkg::CFG_TIMER_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_en_ff <= lin_ctrl_pkg::IRQ_EN_RESET;
      end else if (wr_irq_en) begin
         irq_en_ff <= reg_req_i.wdata[7:0];
      end
   end

   // detector load wins over a software write in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         div_low_ff <= lin_ctrl_pkg::DIV_LOW_RESET;
         div_high_ff <= lin_ctrl_pkg::DIV_HIGH_RESET;
      end else if (sync_done) begin
         {div_high_ff, div_low_ff} <= sync_span[lin_ctrl_pkg::DIV_W-1:0]
                                      - 15'h0001;
      end else begin
         // debug use only: no lower bound is enforced here
         if (wr_div_low) begin
            div_low_ff <= reg_req_i.wdata[7:0];
         end
         if (wr_div_high) begin
            div_high_ff <= reg_req_i.wdata[6:0];
         end
      end
   end

   // break/sync detector
   assign break_thr = lin_ctrl_pkg::SD_CNT_W'(bit_len) *
                      lin_ctrl_pkg::SD_CNT_W'(lin_ctrl_pkg::BREAK_BITS);
   assign sync_span = (sd_cnt_ff + 20'h00001) >>
                      lin_ctrl_pkg::SYNC_SPAN_SHIFT;
   assign sync_done = (sd_state_ff == SD_MEASURE) && bus_fall &&
      (sd_edges_ff == 3'(lin_ctrl_pkg::SYNC_FALL_EDGES - 1));

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sd_state_ff <= SD_IDLE;
         sd_cnt_ff <= '0;
         sd_edges_ff <= '0;
      end else begin
         unique case (sd_state_ff)
            SD_IDLE: begin
               // own transmission must not look like a break
               if (bus_fall && !tx_active) begin
                  sd_cnt_ff <= '0;
                  sd_state_ff <= SD_LOW;
               end
            end
            SD_LOW: begin
               if (bus_rise) begin
                  if (sd_cnt_ff > break_thr) begin
                     sd_state_ff <= SD_WAIT_START;
                  end else begin
                     sd_state_ff <= SD_IDLE;
                  end
               end else if (sd_cnt_ff != '1) begin
                  sd_cnt_ff <= sd_cnt_ff + 20'h00001;
               end
            end
            SD_WAIT_START: begin
               if (bus_fall) begin
                  sd_cnt_ff <= '0;
                  sd_edges_ff <= 3'h1;
                  sd_state_ff <= SD_MEASURE;
               end
            end
            SD_MEASURE: begin
               if (sd_cnt_ff == '1) begin
                  sd_state_ff <= SD_IDLE;
               end else if (sync_done) begin
                  sd_state_ff <= SD_IDLE;
               end else begin
                  sd_cnt_ff <= sd_cnt_ff + 20'h00001;
                  if (bus_fall) begin
                     sd_edges_ff <= sd_edges_ff + 3'h1;
                  end
               end
            end
         endcase
      end
   end

   // receiver: 8N1, lsb first, sampled mid-bit
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_en_ff <= 1'b0;
      end else if (sync_done) begin
         rx_en_ff <= 1'b1;
      end else if (tx_load) begin
         rx_en_ff <= 1'b0;
      end
   end

   assign rx_store = (rx_state_ff == RX_STOP) && (rx_cnt_ff == '0) &&
                     rx_sync_ff;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_state_ff <= RX_IDLE;
         rx_cnt_ff <= '0;
         rx_bits_ff <= '0;
         rx_shift_ff <= '0;
      end else if (sync_done || tx_load) begin
         rx_state_ff <= RX_IDLE;
      end else begin
         unique case (rx_state_ff)
            RX_IDLE: begin
               if (rx_en_ff && !tx_active && bus_fall) begin
                  rx_cnt_ff <= half_bit;
                  rx_state_ff <= RX_START;
               end
            end
            RX_START: begin
               if (rx_cnt_ff != '0) begin
                  rx_cnt_ff <= rx_cnt_ff - 16'h0001;
               end else if (!rx_sync_ff) begin
                  rx_cnt_ff <= bit_len - 16'h0001;
                  rx_bits_ff <= '0;
                  rx_state_ff <= RX_DATA;
               end else begin
                  // glitch, not a start bit
                  rx_state_ff <= RX_IDLE;
               end
            end
            RX_DATA: begin
               if (rx_cnt_ff != '0) begin
                  rx_cnt_ff <= rx_cnt_ff - 16'h0001;
               end else begin
                  rx_shift_ff <= {rx_sync_ff, rx_shift_ff[7:1]};
                  rx_bits_ff <= rx_bits_ff + 3'h1;
                  rx_cnt_ff <= bit_len - 16'h0001;
                  if (rx_bits_ff == 3'h7) begin
                     rx_state_ff <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               // a bad stop bit drops the byte silently
               if (rx_cnt_ff != '0) begin
                  rx_cnt_ff <= rx_cnt_ff - 16'h0001;
               end else begin
                  rx_state_ff <= RX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_buf_ff <= '0;
      end else if (rx_store && !status_ff.receive_buffer_full) begin
         rx_buf_ff <= rx_shift_ff;
      end
   end

   // transmitter: buffer holds one byte, transmit_buffer_empty marks it
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_buf_ff <= '0;
      end else if (wr_data && status_ff.transmit_buffer_empty) begin
         tx_buf_ff <= reg_req_i.wdata[7:0];
      end
   end

   assign tx_load = (tx_state_ff == TX_IDLE) &&
                    !status_ff.transmit_buffer_empty;
   // compare mid-bit; the echo delay of the transceiver is well inside
   assign tx_conflict = tx_active && (tx_cnt_ff == half_bit) &&
                        lin_tx_ff && !rx_sync_ff;
   assign tx_forced_off = tx_active && (tx_cnt_ff == half_bit) &&
                          !lin_tx_ff && rx_sync_ff;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_state_ff <= TX_IDLE;
         tx_shift_ff <= '1;
         tx_cnt_ff <= '0;
         tx_bits_ff <= '0;
         lin_tx_ff <= 1'b1;
      end else begin
         unique case (tx_state_ff)
            TX_IDLE: begin
               if (tx_load) begin
                  tx_shift_ff <= {1'b1, tx_buf_ff};
                  lin_tx_ff <= 1'b0;
                  tx_cnt_ff <= bit_len - 16'h0001;
                  tx_bits_ff <= '0;
                  tx_state_ff <= TX_BIT;
               end
            end
            TX_BIT: begin
               if (tx_conflict || tx_forced_off) begin
                  lin_tx_ff <= 1'b1;
                  tx_state_ff <= TX_IDLE;
               end else if (tx_cnt_ff != '0) begin
                  tx_cnt_ff <= tx_cnt_ff - 16'h0001;
               end else if (tx_bits_ff ==
                            4'(lin_ctrl_pkg::FRAME_LAST_BIT)) begin
                  lin_tx_ff <= 1'b1;
                  tx_state_ff <= TX_IDLE;
               end else begin
                  lin_tx_ff <= tx_shift_ff[0];
                  tx_shift_ff <= {1'b1, tx_shift_ff[8:1]};
                  tx_bits_ff <= tx_bits_ff + 4'h1;
                  tx_cnt_ff <= bit_len - 16'h0001;
               end
            end
         endcase
      end
   end

   // bus inactivity timer
   assign idle_expire = timer_en_ff && !idle_fired_ff &&
                        (idle_cnt_ff == 32'(INACTIVE_CYCLES));

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         idle_cnt_ff <= '0;
         idle_fired_ff <= 1'b0;
      end else if (!timer_en_ff || bus_fall || bus_rise) begin
         idle_cnt_ff <= '0;
         idle_fired_ff <= 1'b0;
      end else if (idle_expire) begin
         idle_fired_ff <= 1'b1;
      end else if (!idle_fired_ff) begin
         idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
      end
   end

   // status: clears first, sets after so a same-cycle event survives
   always_comb begin
      nxt_status = status_ff;
      if (rd_status) begin
         nxt_status = lin_ctrl_pkg::status_type'(status_ff &
                      ~lin_ctrl_pkg::STATUS_RC_MASK);
      end
      if (rd_data) begin
         nxt_status.receive_buffer_full = 1'b0;
      end
      if (wr_data && status_ff.transmit_buffer_empty) begin
         nxt_status.transmit_buffer_empty = 1'b0;
      end
      if (sync_done) begin
         nxt_status.break_field_seen = 1'b1;
      end
      if (rx_store) begin
         if (status_ff.receive_buffer_full) begin
            nxt_status.receive_overrun = 1'b1;
         end else begin
            nxt_status.receive_buffer_full = 1'b1;
         end
      end
      if (tx_load) begin
         nxt_status.transmit_buffer_empty = 1'b1;
      end
      if (tx_conflict) begin
         nxt_status.conflict = 1'b1;
      end
      if (wr_data && !status_ff.transmit_buffer_empty) begin
         nxt_status.write_collision = 1'b1;
      end
      if (tx_forced_off) begin
         nxt_status.transmitter_forced_off = 1'b1;
      end
      if (idle_expire) begin
         nxt_status.bus_inactive = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         status_ff <= lin_ctrl_pkg::status_type'(lin_ctrl_pkg::STATUS_RESET);
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_ff <= 1'b0;
      end else if (wr_irq_en) begin
         // follow a new mask at once, so irq never lags an enable change
         irq_ff <= |(nxt_status & reg_req_i.wdata[7:0]);
      end else begin
         irq_ff <= |(nxt_status & irq_en_ff);
      end
   end

   // read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= '0;
         if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
               lin_ctrl_pkg::ADDR_CONFIG: begin
                  rdata_ff[lin_ctrl_pkg::CFG_TIMER_EN_BIT] <= timer_en_ff;
               end
               lin_ctrl_pkg::ADDR_STATUS: begin
                  rdata_ff[7:0] <= status_ff;
               end
               lin_ctrl_pkg::ADDR_DATA: begin
                  rdata_ff[7:0] <= rx_buf_ff;
               end
               lin_ctrl_pkg::ADDR_IRQ_EN: begin
                  rdata_ff[7:0] <= irq_en_ff;
               end
               lin_ctrl_pkg::ADDR_DIV_LOW: begin
                  rdata_ff[7:0] <= div_low_ff;
               end
               lin_ctrl_pkg::ADDR_DIV_HIGH: begin
                  rdata_ff[6:0] <= div_high_ff;
               end
               default: begin
                  rdata_ff <= '0;
               end
            endcase
         end
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign irq_o = irq_ff;
   assign lin_tx_o = lin_tx_ff;

endmodule // lin_controller

//--- testbench/lin_controller_chk.sv
`timescale 1ns/100ps
module lin_controller_chk #(
   parameter int unsigned INACTIVE_CYCLES = 200
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire lin_ctrl_pkg::reg_req_type reg_req_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic irq_o,
   input wire logic lin_rx_i,
   input wire logic lin_tx_o
);
   logic [7:0] en_shadow_ff;
   logic rd_status;
   logic rd_irq_en;
   logic rd_div_high;
   logic wr_data;

   assign rd_status = reg_req_i.rd
      && reg_req_i.addr == lin_ctrl_pkg::ADDR_STATUS;
   assign rd_irq_en = reg_req_i.rd
      && reg_req_i.addr == lin_ctrl_pkg::ADDR_IRQ_EN;
   assign rd_div_high = reg_req_i.rd
      && reg_req_i.addr == lin_ctrl_pkg::ADDR_DIV_HIGH;
   assign wr_data = reg_req_i.wr && reg_req_i.addr == lin_ctrl_pkg::ADDR_DATA;

   // shadow of the enable mask, so irq can be judged against it
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         en_shadow_ff <= lin_ctrl_pkg::IRQ_EN_RESET;
      end else if (reg_req_i.wr &&
                   reg_req_i.addr == lin_ctrl_pkg::ADDR_IRQ_EN) begin
         en_shadow_ff <= reg_req_i.wdata[7:0];
      end
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence data_write;
      wr_data;
   endsequence

   sequence status_read;
      rd_status;
   endsequence

   chk_rdata_idle: assert property (
      !$past(reg_req_i.rd) |-> reg_rdata_o == 32'h0)
      else $error("read data not zero outside a read answer");
   chk_upper_zero: assert property (
      reg_req_i.rd |=> reg_rdata_o[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   chk_div_high_width: assert property (
      rd_div_high |=> reg_rdata_o[31:7] == 25'h0)
      else $error("divisor high wider than seven bits");
   chk_irq_masked: assert property (
      en_shadow_ff == 8'h00 |-> !irq_o)
      else $error("irq high with all enables clear");
   chk_irq_en_read: assert property (
      rd_irq_en |=> reg_rdata_o == {24'h0, en_shadow_ff})
      else $error("irq enable reads back wrong");
   chk_txe_cleared: assert property (
      data_write ##1 status_read |=> !reg_rdata_o[2])
      else $error("tx empty still set after data write");
   chk_collision_flag: assert property (
      data_write ##1 data_write ##1 status_read |=> reg_rdata_o[5])
      else $error("no write collision on back to back writes");
   chk_level_flags_kept: assert property (
      status_read ##1 status_read |=>
      (reg_rdata_o[2:1] | ~$past(reg_rdata_o[2:1])) == 2'b11)
      else $error("status read cleared rx full or tx empty");
endmodule // lin_controller_chk

//--- testbench/lin_bus_model.sv
`timescale 1ns/100ps
module lin_bus_model #(
   parameter int BIT_LEN = 16
) (
   input wire logic clk_sys_i,
   input wire logic lin_tx_i,
   output logic lin_rx_o
);
   logic node_drive_ff = 1'b1;
   // 0 wired-and echo, 1 bus stuck dominant, 2 output driver cut off
   logic [1:0] fault_mode = 2'h0;
   logic [7:0] seen_q[$];
   logic [7:0] shift;

   assign lin_rx_o = (fault_mode == 2'h1) ? 1'b0 :
      (fault_mode == 2'h2) ? 1'b1 : (lin_tx_i & node_drive_ff);

   task automatic hold(input logic lvl, input int n);
      node_drive_ff <= lvl;
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic send_byte(input logic [7:0] b, input int bl);
      hold(1'b0, bl);
      for (int i = 0; i < 8; i++) begin
         hold(b[i], bl);
      end
      hold(1'b1, bl);
   endtask

   // mid-bit sampler for what the controller sends, lsb first
   initial begin
      forever begin
         @(negedge lin_tx_i);
         repeat (BIT_LEN / 2) @(posedge clk_sys_i);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_LEN) @(posedge clk_sys_i);
            shift = {lin_tx_i, shift[7:1]};
         end
         seen_q.push_back(shift);
      end
   end
endmodule // lin_bus_model

//--- testbench/lin_controller_tb.sv
`timescale 1ns/100ps
module lin_controller_tb;
   localparam int unsigned INACT = 200;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   lin_ctrl_pkg::reg_req_type req = '0;
   logic [31:0] rdata;
   logic irq;
   logic lin_rx;
   logic lin_tx;
   int miscompares = 0;
   int cmp_count = 0;

   always #4 clk_sys_i = ~clk_sys_i;

   lin_controller #(.INACTIVE_CYCLES(INACT)) i_dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .irq_o(irq), .lin_rx_i(lin_rx), .lin_tx_o(lin_tx));
   lin_bus_model #(.BIT_LEN(16)) i_bus (
      .clk_sys_i(clk_sys_i), .lin_tx_i(lin_tx), .lin_rx_o(lin_rx));

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp,
         input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // a write leaves the strobe up; the next call replaces or drops it
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys_i);
   endtask

   task automatic tick(input int n);
      req <= '0;
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp,
         input string name);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_sys_i);
      tick(1);
      check(name, exp, rdata);
   endtask

   task automatic rd2c(input logic [31:0] a, input logic [31:0] e1,
         input logic [31:0] e2, input string name);
      logic [31:0] first;
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      repeat (2) @(posedge clk_sys_i);
      first = rdata;
      tick(1);
      check(name, e1, first);
      check(name, e2, rdata);
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys_i);
      $display("BAD run time expected finish seen timeout");
      miscompares++;
      results();
   end

   initial begin
      int n;
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      // timer still disabled, so the idle wait raises nothing
      tick(300);
      rdc(lin_ctrl_pkg::ADDR_STATUS, 32'h04, "status");
      rdc(lin_ctrl_pkg::ADDR_DATA, 32'h0, "data");
      rdc(lin_ctrl_pkg::ADDR_IRQ_EN, 32'h0, "irq enable");
      rdc(lin_ctrl_pkg::ADDR_DIV_LOW, 32'he7, "div low");
      rdc(lin_ctrl_pkg::ADDR_DIV_HIGH, 32'h03, "div high");
      rdc(32'h4000_1818, 32'h0, "unmapped");
      wr(lin_ctrl_pkg::ADDR_IRQ_EN, 32'hffff_ffff);
      rdc(lin_ctrl_pkg::ADDR_IRQ_EN, 32'hff, "irq enable");
      check("irq", 32'h1, {31'h0, irq});
      wr(lin_ctrl_pkg::ADDR_IRQ_EN, 32'h0);
      tick(2);
      check("irq", 32'h0, {31'h0, irq});
      $display("registers test done");
      wr(lin_ctrl_pkg::ADDR_CONFIG, 32'h8);
      rdc(lin_ctrl_pkg::ADDR_CONFIG, 32'h8, "config");
      tick(INACT + 20);
      rd2c(lin_ctrl_pkg::ADDR_STATUS, 32'h84, 32'h04, "idle");
      wr(lin_ctrl_pkg::ADDR_CONFIG, 32'h0);
      $display("inactivity test done");
      // debug divisor of 32 clocks, then a 16 clock sync must replace it
      wr(lin_ctrl_pkg::ADDR_DIV_LOW, 32'h1f);
      wr(lin_ctrl_pkg::ADDR_DIV_HIGH, 32'h0);
      tick(1);
      i_bus.hold(1'b0, 600);
      i_bus.hold(1'b1, 40);
      i_bus.send_byte(8'h55, 16);
      tick(4);
      rd2c(lin_ctrl_pkg::ADDR_STATUS, 32'h05, 32'h04, "sync");
      rdc(lin_ctrl_pkg::ADDR_DIV_LOW, 32'h0f, "div low");
      rdc(lin_ctrl_pkg::ADDR_DIV_HIGH, 32'h00, "div high");
      $display("sync test done");
      wr(lin_ctrl_pkg::ADDR_IRQ_EN, 32'h02);
      tick(1);
      i_bus.send_byte(8'ha5, 16);
      tick(4);
      check("irq", 32'h1, {31'h0, irq});
      rd2c(lin_ctrl_pkg::ADDR_STATUS, 32'h06, 32'h06, "rx");
      rdc(lin_ctrl_pkg::ADDR_DATA, 32'ha5, "rx byte");
      check("irq", 32'h0, {31'h0, irq});
      i_bus.send_byte(8'h11, 16);
      i_bus.send_byte(8'h22, 16);
      tick(4);
      rd2c(lin_ctrl_pkg::ADDR_STATUS, 32'h16, 32'h06, "overrun");
      rdc(lin_ctrl_pkg::ADDR_DATA, 32'h11, "kept byte");
      rdc(lin_ctrl_pkg::ADDR_STATUS, 32'h04, "status");
      $display("receive test done");
      wr(lin_ctrl_pkg::ADDR_DATA, 32'h1c3);
      rdc(lin_ctrl_pkg::ADDR_STATUS, 32'h00, "tx taken");
      wr(lin_ctrl_pkg::ADDR_DATA, 32'h5a);
      wr(lin_ctrl_pkg::ADDR_DATA, 32'h77);
      rdc(lin_ctrl_pkg::ADDR_STATUS, 32'h20, "collision");
      for (n = 0; n < 1000 && i_bus.seen_q.size() < 2; n++) begin
         @(posedge clk_sys_i);
      end
      if (i_bus.seen_q.size() < 2) begin
         $display("BAD tx bytes expected 2 seen %0d", i_bus.seen_q.size());
         miscompares++;
         results();
      end
      check("tx byte", 32'hc3, {24'h0, i_bus.seen_q[0]});
      check("tx byte", 32'h5a, {24'h0, i_bus.seen_q[1]});
      tick(24);
      rdc(lin_ctrl_pkg::ADDR_STATUS, 32'h04, "tx drained");
      $display("transmit test done");
      wr(lin_ctrl_pkg::ADDR_DATA, 32'hff);
      i_bus.fault_mode <= 2'h1;
      tick(60);
      i_bus.fault_mode <= 2'h0;
      rdc(lin_ctrl_pkg::ADDR_STATUS, 32'h0c, "conflict");
      wr(lin_ctrl_pkg::ADDR_DATA, 32'h00);
      i_bus.fault_mode <= 2'h2;
      tick(60);
      i_bus.fault_mode <= 2'h0;
      rdc(lin_ctrl_pkg::ADDR_STATUS, 32'h44, "driver off");
      $display("fault test done");
      results();
   end
endmodule // lin_controller_tb

bind lin_controller lin_controller_chk #(
   .INACTIVE_CYCLES(INACTIVE_CYCLES)
) i_chk (
   .clk_sys_i(clk_sys_i),
   .rst_i(rst_i),
   .reg_req_i(reg_req_i),
   .reg_rdata_o(reg_rdata_o),
   .irq_o(irq_o),
   .lin_rx_i(lin_rx_i),
   .lin_tx_o(lin_tx_o)
);
